// ### design/cobi_pkg.sv
// cobi_pkg: shared types and constants of the cache-operation and bus-interface block.
// assumes one core clock; queue ids double as bus transaction tags.
package cobi_pkg;

  // ==========================================================================
  // geometry and limits
  localparam int ADDR_W       = 32;
  localparam int BLK_OFF      = 5;    // eight-word cache block
  localparam int IC_WAYS      = 4;    // instruction cache ways per index
  localparam int NQ           = 5;    // address queues
  localparam int MAX_INFLIGHT = 2;    // one-level address pipelining

  // ==========================================================================
  // queue ids, lowest id is highest bus priority
  localparam logic [2:0] Q_SCB = 3'h0;  // snoop copy-back
  localparam logic [2:0] Q_CST = 3'h1;  // cast-out and store
  localparam logic [2:0] Q_DCL = 3'h2;  // data cache load
  localparam logic [2:0] Q_ICL = 3'h3;  // instruction cache load
  localparam logic [2:0] Q_TCH = 3'h4;  // touch load

  // ==========================================================================
  // encodings
  typedef enum logic [1:0] {
    MEI_I = 2'h0,
    MEI_E = 2'h1,
    MEI_M = 2'h2
  } cobi_mei_t;

  typedef enum logic [2:0] {
    BUS_READ   = 3'h0,
    BUS_RWITM  = 3'h1,
    BUS_WRITE  = 3'h2,
    BUS_WWK    = 3'h3,
    BUS_KILL   = 3'h4,
    BUS_WFLUSH = 3'h5,
    BUS_CLEAN  = 3'h6,
    BUS_FLUSH  = 3'h7
  } cobi_cmd_t;

  typedef enum logic [3:0] {
    OP_IOORD   = 4'h0,  // i/o ordering
    OP_ICINV   = 4'h1,  // instruction block invalidate
    OP_FBAR    = 4'h2,  // fetch barrier
    OP_MBAR    = 4'h3,  // memory barrier
    OP_DCINV   = 4'h4,  // data block invalidate
    OP_DCFLUSH = 4'h5,
    OP_DCSTORE = 4'h6,
    OP_DCZERO  = 4'h7,
    OP_TOUCH   = 4'h8,
    OP_TOUCHST = 4'h9
  } cobi_op_code_t;

  // ==========================================================================
  // carriers
  typedef struct packed {
    logic                valid;
    cobi_op_code_t       code;
    logic [ADDR_W-1:0]   effective_address;
    cobi_mei_t           state;   // current state of the addressed data block
  } cobi_op_t;

  typedef struct packed {
    logic                valid;
    cobi_cmd_t           cmd;
    logic                inhib;   // cache-inhibited access
    logic [ADDR_W-1:0]   addr;
  } cobi_req_t;

  typedef struct packed {
    logic                valid;
    logic                issued;
    cobi_cmd_t           cmd;
    logic                inhib;
    logic [ADDR_W-1:0]   addr;
  } cobi_qent_t;

  typedef struct packed {
    logic                valid;
    cobi_cmd_t           cmd;
    logic [2:0]          tag;
    logic [ADDR_W-1:0]   addr;
  } cobi_bus_t;

  typedef struct packed {
    logic                valid;
    cobi_mei_t           next_state;
    logic                zero;    // clear all bytes of the block
    logic [ADDR_W-1:0]   addr;
  } cobi_upd_t;

  typedef struct packed {
    logic                valid;
    logic [IC_WAYS-1:0]  ways;
    logic [ADDR_W-1:0]   effective_address;
  } cobi_icinv_t;

endpackage : cobi_pkg

// ### design/cobi_unit.sv
// cobi_unit: cache maintenance operations and the core's bus address queues.
// assumes the caches, pipeline and bus arbiter all run on i_ref_clk.
`timescale 1ns/1ps

module cobi_unit
  import cobi_pkg::*;
(
  input  wire logic              i_ref_clk,
  input  wire logic              i_reset_n,
  input  wire cobi_op_t          i_op,
  output logic                   o_op_ready,
  output logic                   o_op_done,
  input  wire logic              i_older_done,
  output logic                   o_fetch_discard,
  output cobi_icinv_t            o_ic_inval,
  output cobi_upd_t              o_dc_upd,
  input  wire cobi_req_t         i_icl,
  output logic                   o_icl_ready,
  input  wire cobi_req_t         i_dcl,
  output logic                   o_dcl_ready,
  output logic                   o_collision,
  input  wire cobi_req_t         i_cst,
  output logic                   o_cst_ready,
  input  wire cobi_req_t         i_scb,
  output logic                   o_scb_ready,
  output cobi_bus_t              o_bus,
  input  wire logic              i_bus_ack,
  input  wire logic              i_bus_done,
  input  wire logic [2:0]        i_bus_done_tag,
  output logic [2:0]             o_bus_done_tag,
  output logic                   o_bus_done,
  input  wire cobi_req_t         i_snoop,
  output logic                   o_snoop_kill,
  output logic [ADDR_W-1:0]      o_snoop_addr,
  output logic                   o_snoop_qhit,
  input  wire cobi_req_t         i_resv_set,
  output logic                   o_resv_valid,
  input  wire logic              i_touch_moved,
  output logic                   o_touch_valid,
  output logic [ADDR_W-1:0]      o_touch_addr
);

  // ==========================================================================
  // helpers
  function automatic logic cobi_same_blk(input logic [ADDR_W-1:0] a,
                                         input logic [ADDR_W-1:0] b);
    cobi_same_blk = (a[ADDR_W-1:BLK_OFF] == b[ADDR_W-1:BLK_OFF]);
  endfunction : cobi_same_blk

  function automatic logic cobi_hit(input cobi_qent_t e, input logic [ADDR_W-1:0] a);
    cobi_hit = e.valid && cobi_same_blk(e.addr, a);
  endfunction : cobi_hit

  typedef enum logic [2:0] {
    ST_IDLE  = 3'h1,
    ST_DRAIN = 3'h2,
    ST_FWAIT = 3'h4
  } cobi_st_t;

  cobi_st_t            st, next_st;
  cobi_qent_t          q [NQ];
  cobi_qent_t          next_q [NQ];
  cobi_bus_t           bus, next_bus;
  cobi_upd_t           upd, next_upd;
  cobi_icinv_t         icinv, next_icinv;
  logic                done, next_done;
  logic                fdisc, next_fdisc;
  logic                resv_v, next_resv_v;
  logic [ADDR_W-1:0]   resv_a, next_resv_a;
  logic                tch_v, next_tch_v;
  logic [ADDR_W-1:0]   tch_a, next_tch_a;
  logic                skill, next_skill;
  logic                sqhit, next_sqhit;
  logic [ADDR_W-1:0]   saddr, next_saddr;
  logic                bdone, next_bdone;
  logic [2:0]          btag, next_btag;

  // op decode results feeding the queue group; queues_idle feeds the sequencer
  logic                need_q, op_go, op_dcm, op_zero;
  logic [2:0]          need_id;
  cobi_cmd_t           need_cmd;
  logic                queues_idle;

  // ==========================================================================
  // operation sequencer
  // decode which queue an operation needs; the op stalls while that queue is full
  always_comb begin
    need_q   = 1'b0;
    need_id  = Q_CST;
    need_cmd = BUS_WWK;
    case (i_op.code)
      OP_DCFLUSH: need_q = (i_op.state == MEI_M);
      OP_DCSTORE: begin
        need_q   = (i_op.state == MEI_M);
        need_cmd = BUS_WRITE;
      end
      OP_DCZERO: begin
        need_q   = 1'b1;
        need_cmd = (i_op.state == MEI_I) ? BUS_WWK : BUS_KILL;
      end
      OP_TOUCH, OP_TOUCHST: begin
        need_q   = (i_op.state == MEI_I);
        need_id  = Q_TCH;
        need_cmd = (i_op.code == OP_TOUCHST) ? BUS_RWITM : BUS_READ;
      end
      default: need_q = 1'b0;
    endcase
    o_op_ready = (st == ST_IDLE) && (!need_q || !q[need_id].valid);
    op_go      = i_op.valid && o_op_ready;
    op_dcm     = op_go && (i_op.code >= OP_DCINV);
    op_zero    = op_go && (i_op.code == OP_DCZERO);
  end

  // bus quiet: nothing queued and nothing presented
  always_comb begin
    queues_idle = !bus.valid;
    for (int i = 0; i < NQ; i++) begin
      if (q[i].valid) begin
        queues_idle = 1'b0;
      end
    end
  end

  // next state and cache-side outputs of the sequencer
  always_comb begin
    next_st    = st;
    next_upd   = '0;
    next_icinv = '0;
    next_done  = 1'b0;
    next_fdisc = 1'b0;
    case (st)
      ST_IDLE: begin
        if (op_go) begin
          next_upd.addr = i_op.effective_address;
          case (i_op.code)
            OP_IOORD: next_done = 1'b1;
            OP_ICINV: begin
              next_icinv.valid             = 1'b1;
              next_icinv.ways              = '1;
              next_icinv.effective_address = i_op.effective_address;
              next_done                    = 1'b1;
            end
            OP_FBAR: next_st = ST_FWAIT;
            OP_MBAR: next_st = ST_DRAIN;
            OP_DCINV, OP_DCFLUSH: begin
              next_upd.valid      = 1'b1;
              next_upd.next_state = MEI_I;
              next_done           = 1'b1;
            end
            OP_DCSTORE: begin
              next_upd.valid      = (i_op.state == MEI_M);
              next_upd.next_state = MEI_E;
              next_done           = 1'b1;
            end
            OP_DCZERO: begin
              next_upd.valid      = 1'b1;
              next_upd.next_state = MEI_M;
              next_upd.zero       = 1'b1;
              next_done           = 1'b1;
            end
            default: next_done = 1'b1;     // touches leave cache state alone
          endcase
        end
      end
      ST_DRAIN: begin
        if (queues_idle) begin
          next_st   = ST_IDLE;
          next_done = 1'b1;
        end
      end
      ST_FWAIT: begin
        if (i_older_done) begin
          next_st    = ST_IDLE;
          next_fdisc = 1'b1;
          next_done  = 1'b1;
        end
      end
      default: next_st = ST_IDLE;
    endcase
  end

  always_ff @(posedge i_ref_clk or negedge i_reset_n) begin
    if (!i_reset_n) begin
      st    <= ST_IDLE;
      upd   <= '0;
      icinv <= '0;
      done  <= 1'b0;
      fdisc <= 1'b0;
    end else begin
      st    <= next_st;
      upd   <= next_upd;
      icinv <= next_icinv;
      done  <= next_done;
      fdisc <= next_fdisc;
    end
  end

  // ==========================================================================
  // address queues, bus issue, snoop and reservation
  logic       pick_ok, ld_ahead;
  logic [2:0] pick_id;
  int         inflight;

  // port readiness; the sequencer owns the cast-out queue when it needs it
  always_comb begin
    o_icl_ready = !q[Q_ICL].valid;
    o_scb_ready = !q[Q_SCB].valid;
    o_cst_ready = !q[Q_CST].valid && !(op_go && need_q && need_id == Q_CST);
    o_collision = i_dcl.valid && (cobi_hit(q[Q_CST], i_dcl.addr) ||
                                  cobi_hit(q[Q_SCB], i_dcl.addr));
    o_dcl_ready = !q[Q_DCL].valid && !o_collision;
  end

  // fixed-priority pick among queued, not yet issued entries
  always_comb begin
    pick_ok  = 1'b0;
    pick_id  = Q_SCB;
    inflight = 0;
    for (int i = NQ - 1; i >= 0; i--) begin
      if (q[i].valid && q[i].issued) begin
        inflight = inflight + 1;
      end
      if (q[i].valid && !q[i].issued) begin
        pick_ok = 1'b1;
        pick_id = i[2:0];
      end
    end
    // a load may pass a plain buffered store, never a cast-out or an inhibited access
    ld_ahead = q[Q_DCL].valid && !q[Q_DCL].issued && !q[Q_DCL].inhib &&
               q[Q_CST].cmd == BUS_WRITE && !q[Q_CST].inhib &&
               !cobi_same_blk(q[Q_CST].addr, q[Q_DCL].addr);
    if (pick_ok && pick_id == Q_CST && ld_ahead) begin
      pick_id = Q_DCL;
    end
  end

  always_comb begin
    next_q      = q;
    next_bus    = bus;
    next_resv_v = resv_v;
    next_resv_a = resv_a;
    next_tch_v  = tch_v;
    next_tch_a  = tch_a;
    next_skill  = 1'b0;
    next_sqhit  = 1'b0;
    next_saddr  = saddr;
    next_bdone  = i_bus_done;
    next_btag   = i_bus_done ? i_bus_done_tag : btag;
    // completion frees the queue; the cache owns the matching data
    if (i_bus_done && i_bus_done_tag < NQ[2:0]) begin
      next_q[i_bus_done_tag].valid = 1'b0;
    end
    // each port loads only its own buffer; the sequencer loads the cast-out or touch buffer
    if (i_icl.valid && o_icl_ready) begin
      next_q[Q_ICL] = '{1'b1, 1'b0, BUS_READ, i_icl.inhib, i_icl.addr};
    end
    if (i_dcl.valid && o_dcl_ready) begin
      next_q[Q_DCL] = '{1'b1, 1'b0, i_dcl.cmd, i_dcl.inhib, i_dcl.addr};
    end
    if (i_cst.valid && o_cst_ready) begin
      next_q[Q_CST] = '{1'b1, 1'b0, i_cst.cmd, i_cst.inhib, i_cst.addr};
    end
    if (i_scb.valid && o_scb_ready) begin
      next_q[Q_SCB] = '{1'b1, 1'b0, BUS_WWK, 1'b0, i_scb.addr};
    end
    if (op_go && need_q) begin
      next_q[need_id] = '{1'b1, 1'b0, need_cmd, 1'b0, i_op.effective_address};
    end
    // touch buffer drops on i_touch_moved, data-cache op, matching zero or new touch
    if (i_touch_moved || op_dcm ||
        (op_zero && cobi_same_blk(tch_a, i_op.effective_address))) begin
      next_tch_v = 1'b0;
    end
    // address-only kills from other masters; other broadcasts still load the snoop address and queue hit, and writes clear the reservation
    if (i_snoop.valid) begin
      next_saddr = i_snoop.addr;
      next_sqhit = cobi_hit(q[Q_CST], i_snoop.addr) ||
                   cobi_hit(q[Q_SCB], i_snoop.addr) ||
                   cobi_hit(q[Q_DCL], i_snoop.addr);
      if (i_snoop.cmd == BUS_KILL) begin
        next_skill = 1'b1;
        if (cobi_same_blk(tch_a, i_snoop.addr)) begin
          next_tch_v = 1'b0;
        end
      end
      if (cobi_same_blk(resv_a, i_snoop.addr) &&
          (i_snoop.cmd == BUS_KILL || i_snoop.cmd == BUS_RWITM ||
           i_snoop.cmd == BUS_WRITE || i_snoop.cmd == BUS_WWK ||
           i_snoop.cmd == BUS_WFLUSH || i_snoop.cmd == BUS_FLUSH)) begin
        next_resv_v = 1'b0;
      end
    end
    // a new reservation wins over a same-cycle snoop clear
    if (i_resv_set.valid) begin
      next_resv_v = 1'b1;
      next_resv_a = i_resv_set.addr;
    end
    // a finished touch fill sets the buffer, winning over any clear
    if (i_bus_done && i_bus_done_tag == Q_TCH) begin
      next_tch_v = 1'b1;
      next_tch_a = q[Q_TCH].addr;
    end
    // request register: held until accepted, two transactions at most
    if (bus.valid && i_bus_ack) begin
      next_bus.valid = 1'b0;
    end
    if (!next_bus.valid && pick_ok && inflight < MAX_INFLIGHT) begin
      next_bus                = '{1'b1, q[pick_id].cmd, pick_id, q[pick_id].addr};
      next_q[pick_id].issued  = 1'b1;
    end
  end

  always_ff @(posedge i_ref_clk or negedge i_reset_n) begin
    if (!i_reset_n) begin
      for (int i = 0; i < NQ; i++) begin
        q[i] <= '0;
      end
      bus    <= '0;
      resv_v <= 1'b0;
      resv_a <= '0;
      tch_v  <= 1'b0;
      tch_a  <= '0;
      skill  <= 1'b0;
      sqhit  <= 1'b0;
      saddr  <= '0;
      bdone  <= 1'b0;
      btag   <= '0;
    end else begin
      q      <= next_q;
      bus    <= next_bus;
      resv_v <= next_resv_v;
      resv_a <= next_resv_a;
      tch_v  <= next_tch_v;
      tch_a  <= next_tch_a;
      skill  <= next_skill;
      sqhit  <= next_sqhit;
      saddr  <= next_saddr;
      bdone  <= next_bdone;
      btag   <= next_btag;
    end
  end

  // ==========================================================================
  // outputs, all from flip-flops except the ready and collision handshakes
  assign o_op_done       = done;
  assign o_fetch_discard = fdisc;
  assign o_ic_inval      = icinv;
  assign o_dc_upd        = upd;
  assign o_bus           = bus;
  assign o_bus_done      = bdone;
  assign o_bus_done_tag  = btag;
  assign o_snoop_kill    = skill;
  assign o_snoop_qhit    = sqhit;
  assign o_snoop_addr    = saddr;
  assign o_resv_valid    = resv_v;
  assign o_touch_valid   = tch_v;
  assign o_touch_addr    = tch_a;

endmodule : cobi_unit

// ### dv/cobi_bus_model.sv
// cobi_bus_model: behavioural system bus behind the unit's address queues.
// assumes the unit's bus port on i_ref_clk; finishes transactions in order after i_lat.
`timescale 1ns/1ps
module cobi_bus_model
  import cobi_pkg::*;
(
  input  wire logic       i_ref_clk,
  input  wire logic       i_reset_n,
  input  wire cobi_bus_t  i_bus,
  input  wire logic [3:0] i_lat,
  output logic            o_ack,
  output logic            o_done,
  output logic [2:0]      o_done_tag
);
  // ==========================================================================
  // address tenure and data phase
  logic [2:0] pend[$];
  int         wait_cnt;

  // ack a cycle late; the tag line toggles between dones so a stale echo is caught
  always @(posedge i_ref_clk or negedge i_reset_n) begin
    if (!i_reset_n) begin
      pend.delete();
      wait_cnt = 0;
      o_ack <= 1'b0;
      o_done <= 1'b0;
      o_done_tag <= 3'h5;
    end else begin
      o_ack <= i_bus.valid && !o_ack;
      if (i_bus.valid && o_ack) pend.push_back(i_bus.tag);
      o_done <= 1'b0;
      o_done_tag <= ~o_done_tag;
      if (pend.size() > 0 && wait_cnt >= int'(i_lat)) begin
        o_done <= 1'b1;
        o_done_tag <= pend.pop_front();
        wait_cnt = 0;
      end else if (pend.size() > 0) begin
        wait_cnt++;
      end
    end
  end
endmodule : cobi_bus_model

// ### dv/cobi_unit_asserts.sv
// cobi_unit_asserts: port-level checks of the cache op and bus interface unit.
// assumes one clock domain; bound to every cobi_unit instance.
`timescale 1ns/1ps
module cobi_unit_asserts
  import cobi_pkg::*;
(
  input wire logic        i_ref_clk,
  input wire logic        i_reset_n,
  input wire cobi_op_t    i_op,
  input wire logic        o_op_ready,
  input wire logic        o_op_done,
  input wire logic        i_older_done,
  input wire logic        o_fetch_discard,
  input wire cobi_icinv_t o_ic_inval,
  input wire cobi_upd_t   o_dc_upd,
  input wire cobi_bus_t   o_bus,
  input wire logic        i_bus_ack,
  input wire logic        i_bus_done,
  input wire logic [2:0]  i_bus_done_tag,
  input wire logic        o_bus_done,
  input wire logic [2:0]  o_bus_done_tag,
  input wire cobi_req_t   i_snoop,
  input wire logic        o_snoop_kill,
  input wire logic [31:0] o_snoop_addr,
  input wire logic        o_touch_valid
);
  // ==========================================================================
  // helper: transactions acked but not finished
  logic [2:0] infl;
  logic [2:0] next_infl;
  logic       take;
  assign take = i_op.valid && o_op_ready;

  // done and ack may land together, so both terms apply in one cycle
  always_comb begin
    next_infl = infl + 3'(o_bus.valid && i_bus_ack) - 3'(i_bus_done);
  end
  always_ff @(posedge i_ref_clk or negedge i_reset_n) begin
    if (!i_reset_n) infl <= 3'h0;
    else infl <= next_infl;
  end

  // a memory barrier is pending from its take until the next op done
  logic mbar_pend;
  always_ff @(posedge i_ref_clk or negedge i_reset_n) begin
    if (!i_reset_n) mbar_pend <= 1'b0;
    else if (take && i_op.code == OP_MBAR) mbar_pend <= 1'b1;
    else if (o_op_done) mbar_pend <= 1'b0;
  end

  // ==========================================================================
  // properties
  default clocking cb @(posedge i_ref_clk); endclocking
  default disable iff (!i_reset_n);

  icinv_ways_a: assert property (
    take && i_op.code == OP_ICINV |=> o_ic_inval.valid && o_ic_inval.ways == 4'hF
    && o_ic_inval.effective_address == $past(i_op.effective_address)) else $error("icinv bad");
  fbar_wait_a: assert property (
    o_fetch_discard |-> o_op_done && $past(i_older_done)) else $error("discard early");
  snoop_kill_a: assert property (
    i_snoop.valid |=> o_snoop_kill == ($past(i_snoop.cmd) == BUS_KILL)
    && o_snoop_addr == $past(i_snoop.addr)) else $error("snoop kill bad");
  no_bcast_a: assert property (
    o_bus.valid |-> o_bus.cmd != BUS_CLEAN && o_bus.cmd != BUS_FLUSH) else $error("broadcast");
  mbar_drain_a: assert property (
    mbar_pend && o_op_done |-> $past(infl == 3'h0 && !o_bus.valid))
    else $error("mbar early");
  done_echo_a: assert property (
    i_bus_done |=> o_bus_done && o_bus_done_tag == $past(i_bus_done_tag))
    else $error("done echo bad");
  flush_inv_a: assert property (
    take && i_op.code == OP_DCFLUSH |=> o_dc_upd.valid && o_dc_upd.next_state == MEI_I)
    else $error("flush state");
  zero_mod_a: assert property (
    take && i_op.code == OP_DCZERO |=> o_dc_upd.valid && o_dc_upd.zero
    && o_dc_upd.next_state == MEI_M) else $error("zero state");
  bus_hold_a: assert property (
    o_bus.valid && !i_bus_ack |=> o_bus.valid && $stable(o_bus)) else $error("bus dropped");
  inflight_max_a: assert property (
    infl <= 3'h2) else $error("over two in flight");
  touch_drop_a: assert property (
    take && i_op.code >= OP_DCINV && !(i_bus_done && i_bus_done_tag == Q_TCH)
    |=> !o_touch_valid) else $error("touch kept");
endmodule : cobi_unit_asserts

bind cobi_unit cobi_unit_asserts chk (.*);

// ### dv/cobi_unit_test.sv
// cobi_unit_test: self-checking bench of the cache op and bus interface unit.
// assumes cobi_bus_model answers the bus; checker bound separately.
`timescale 1ns/1ps
`define CHK(n, e, g) begin checks++; if ((g) !== (e)) begin error_cnt++; \
  $display("[FAIL] %s exp %0h got %0h", n, e, g); end end
module cobi_unit_test import cobi_pkg::*;;
  logic        i_ref_clk, i_reset_n, i_older_done, i_bus_ack, i_bus_done, i_touch_moved;
  logic        o_op_ready, o_op_done, o_fetch_discard, o_icl_ready, o_dcl_ready;
  logic        o_collision, o_cst_ready, o_scb_ready, o_bus_done, o_snoop_kill;
  logic        o_snoop_qhit, o_resv_valid, o_touch_valid;
  logic [2:0]  i_bus_done_tag, o_bus_done_tag;
  logic [31:0] o_snoop_addr, o_touch_addr;
  logic [3:0]  lat;
  cobi_op_t    i_op;
  cobi_req_t   i_icl, i_dcl, i_cst, i_scb, i_snoop, i_resv_set;
  cobi_icinv_t o_ic_inval;
  cobi_upd_t   o_dc_upd;
  cobi_bus_t   o_bus;
  int          error_cnt, checks, cyc, nacc, ndone;
  logic [5:0]  seen[$];

  cobi_unit uut (.*);
  cobi_bus_model bus_mdl (.i_ref_clk, .i_reset_n, .i_bus(o_bus), .i_lat(lat),
    .o_ack(i_bus_ack), .o_done(i_bus_done), .o_done_tag(i_bus_done_tag));

  // ==========================================================================
  // clock, bus monitor and hang limit
  initial begin
    i_ref_clk = 1'b0;
    forever #5 i_ref_clk = ~i_ref_clk;
  end
  always @(posedge i_ref_clk) begin
    cyc++;
    if (i_reset_n && o_bus.valid && i_bus_ack) begin
      seen.push_back({o_bus.tag, o_bus.cmd});
      nacc++;
    end
    if (i_reset_n && i_bus_done) ndone++;
    if (cyc == 20000) begin
      error_cnt++;
      finish_test();
    end
  end

  // ==========================================================================
  // shared drivers
  task automatic do_op(cobi_op_code_t c, cobi_mei_t s, logic [31:0] a);
    @(posedge i_ref_clk);
    i_op <= '{1'b1, c, a, s};
    @(posedge i_ref_clk);
    for (int i = 0; i < 50 && o_op_ready !== 1'b1; i++) @(posedge i_ref_clk);
    i_op.valid <= 1'b0;
    #1;
  endtask : do_op
  // a request reaches the bus a cycle after its queue loads, so let it show first
  task automatic wait_idle();
    repeat (3) @(posedge i_ref_clk);
    #1;
    for (int i = 0; i < 300 && (nacc != ndone || o_bus.valid !== 1'b0); i++)
      @(posedge i_ref_clk) #1;
    `CHK("bus_idle", 2'h2, {nacc == ndone, o_bus.valid})
    repeat (2) @(posedge i_ref_clk);
    #1;
  endtask : wait_idle
  task automatic snp(cobi_cmd_t c, logic [31:0] a);
    @(posedge i_ref_clk);
    i_snoop <= '{1'b1, c, 1'b0, a};
    @(posedge i_ref_clk);
    i_snoop.valid <= 1'b0;
    #1;
  endtask : snp

  // ==========================================================================
  // scenarios
  task automatic t_sync_ops();
    do_op(OP_IOORD, MEI_I, 32'h0);
    `CHK("ioord", 3'h4, {o_op_done, o_dc_upd.valid, o_bus.valid})
    do_op(OP_ICINV, MEI_M, 32'h0000_1240);
    `CHK("icinv", {1'b1, 4'hF, 32'h0000_1240}, o_ic_inval)
    do_op(OP_FBAR, MEI_I, 32'h0);
    repeat (3) @(posedge i_ref_clk);
    `CHK("fbar_wait", 2'h0, {o_op_done, o_fetch_discard})
    i_older_done <= 1'b1;
    @(posedge i_ref_clk);
    #1;
    `CHK("fbar_done", 2'h3, {o_op_done, o_fetch_discard})
    lat <= 4'hC;
    @(posedge i_ref_clk);
    i_icl <= '{1'b1, BUS_READ, 1'b0, 32'h0000_2000};
    @(posedge i_ref_clk);
    i_icl.valid <= 1'b0;
    do_op(OP_MBAR, MEI_I, 32'h0);
    for (int i = 0; i < 100 && o_op_done !== 1'b1; i++) @(posedge i_ref_clk) #1;
    `CHK("mbar_drain", ndone, nacc)
    `CHK("mbar_done", 1'b1, o_op_done)
    `CHK("done_tag", {1'b0, Q_ICL}, {o_bus_done, o_bus_done_tag})
  endtask : t_sync_ops

  // data-cache ops: resulting state and bus command (8 means no traffic)
  task automatic t_dcops();
    cobi_op_code_t c[6] = '{OP_DCFLUSH, OP_DCFLUSH, OP_DCSTORE, OP_DCZERO, OP_DCZERO, OP_DCINV};
    cobi_mei_t     s[6] = '{MEI_E, MEI_M, MEI_M, MEI_I, MEI_E, MEI_M};
    cobi_mei_t     n[6] = '{MEI_I, MEI_I, MEI_E, MEI_M, MEI_M, MEI_I};
    logic [3:0]    b[6] = '{4'h8, 4'h3, 4'h2, 4'h3, 4'h4, 4'h8};
    lat <= 4'h1;
    for (int k = 0; k < 6; k++) begin
      seen.delete();
      do_op(c[k], s[k], 32'h0000_3000 + 32'(k) * 32'h20);
      `CHK("dc_upd", {1'b1, n[k]}, {o_dc_upd.valid, o_dc_upd.next_state})
      `CHK("dc_zero", c[k] == OP_DCZERO, o_dc_upd.zero)
      wait_idle();
      `CHK("bus_cnt", b[k] != 4'h8, seen.size() == 1)
      if (b[k] != 4'h8) `CHK("bus_cmd", {Q_CST, b[k][2:0]}, seen[0])
    end
  endtask : t_dcops

  task automatic t_touch();
    seen.delete();
    do_op(OP_TOUCH, MEI_I, 32'h0000_4020);
    wait_idle();
    `CHK("touch_rd", {Q_TCH, BUS_READ}, seen[0])
    `CHK("touch_buf", {1'b1, 32'h0000_4020}, {o_touch_valid, o_touch_addr})
    do_op(OP_TOUCH, MEI_E, 32'h0000_4040);
    `CHK("touch_new", 1'b0, o_touch_valid)
    do_op(OP_TOUCHST, MEI_I, 32'h0000_4060);
    wait_idle();
    `CHK("touchst", {2'h2, Q_TCH, BUS_RWITM}, {seen.size() == 2, 1'b0, seen[1]})
    do_op(OP_DCZERO, MEI_E, 32'h0000_4064);
    `CHK("touch_zero", 1'b0, o_touch_valid)
    wait_idle();
    do_op(OP_TOUCH, MEI_I, 32'h0000_4080);
    wait_idle();
    `CHK("touch_fill", 1'b1, o_touch_valid)
    @(posedge i_ref_clk);
    i_touch_moved <= 1'b1;
    @(posedge i_ref_clk);
    i_touch_moved <= 1'b0;
    #1;
    `CHK("touch_moved", 1'b0, o_touch_valid)
  endtask : t_touch

  task automatic t_queues();
    lat <= 4'h6;
    seen.delete();
    @(posedge i_ref_clk);
    i_icl <= '{1'b1, BUS_READ, 1'b0, 32'h0000_5000};
    i_dcl <= '{1'b1, BUS_READ, 1'b0, 32'h0000_5100};
    i_cst <= '{1'b1, BUS_WWK, 1'b0, 32'h0000_5200};
    i_scb <= '{1'b1, BUS_WWK, 1'b0, 32'h0000_5300};
    @(posedge i_ref_clk);
    {i_icl.valid, i_dcl.valid, i_cst.valid, i_scb.valid} <= 4'h0;
    wait_idle();
    `CHK("prio", {Q_SCB, BUS_WWK, Q_CST, BUS_WWK, Q_DCL, BUS_READ, Q_ICL, BUS_READ},
      {seen[0], seen[1], seen[2], seen[3]})
    seen.delete();
    @(posedge i_ref_clk);
    i_cst <= '{1'b1, BUS_WRITE, 1'b0, 32'h0000_6000};
    i_dcl <= '{1'b1, BUS_READ, 1'b0, 32'h0000_6100};
    @(posedge i_ref_clk);
    {i_dcl.valid, i_cst.valid} <= 2'h0;
    wait_idle();
    `CHK("loadahead", {Q_DCL, BUS_READ}, seen[0])
    seen.delete();
    @(posedge i_ref_clk);
    i_cst <= '{1'b1, BUS_WWK, 1'b0, 32'h0000_6200};
    @(posedge i_ref_clk);
    i_cst.valid <= 1'b0;
    i_dcl <= '{1'b1, BUS_READ, 1'b0, 32'h0000_6208};
    #1;
    `CHK("collision", 1'b1, o_collision)
    for (int i = 0; i < 100 && o_dcl_ready !== 1'b1; i++) @(posedge i_ref_clk);
    i_dcl.valid <= 1'b0;
    wait_idle();
    `CHK("coll_order", {Q_CST, BUS_WWK, Q_DCL, BUS_READ}, {seen[0], seen[1]})
  endtask : t_queues

  task automatic t_snoop();
    @(posedge i_ref_clk);
    i_resv_set <= '{1'b1, BUS_READ, 1'b0, 32'h0000_7000};
    @(posedge i_ref_clk);
    i_resv_set.valid <= 1'b0;
    snp(BUS_READ, 32'h0000_7004);
    `CHK("resv_read", 2'h2, {o_resv_valid, o_snoop_kill})
    snp(BUS_RWITM, 32'h0000_7010);
    `CHK("resv_lost", 1'b0, o_resv_valid)
    snp(BUS_KILL, 32'h0000_7100);
    `CHK("kill", {1'b1, 32'h0000_7100}, {o_snoop_kill, o_snoop_addr})
    lat <= 4'h9;
    @(posedge i_ref_clk);
    i_cst <= '{1'b1, BUS_WWK, 1'b0, 32'h0000_7200};
    @(posedge i_ref_clk);
    i_cst.valid <= 1'b0;
    snp(BUS_READ, 32'h0000_7204);
    `CHK("snoop_qhit", 1'b1, o_snoop_qhit)
    wait_idle();
  endtask : t_snoop

  // ==========================================================================
  // closing report, the single end of the run
  task automatic finish_test();
    $display("checks %0d errors %0d", checks, error_cnt);
    if (error_cnt == 0 && checks > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask : finish_test

  // main sequence
  initial begin
    {i_reset_n, i_older_done, i_touch_moved} = 3'h0;
    {i_op, i_icl, i_dcl, i_cst, i_scb, i_snoop, i_resv_set} = '0;
    lat = 4'h1;
    repeat (16) @(posedge i_ref_clk);
    i_reset_n <= 1'b1;
    @(posedge i_ref_clk);
    #1;
    `CHK("ready_rst", 5'h1F, {o_op_ready, o_icl_ready, o_dcl_ready, o_cst_ready, o_scb_ready})
    t_sync_ops();
    t_dcops();
    t_touch();
    t_queues();
    t_snoop();
    finish_test();
  end
endmodule : cobi_unit_test
